/* File: src/lcu_defines.vh */
`ifndef LCU_DEFINES_VH
`define LCU_DEFINES_VH
// register word addresses (one 32-bit word each)
`define LCU_ADDR_RXBUF 4'h0
`define LCU_ADDR_TXBUF 4'h1
`define LCU_ADDR_MODE 4'h2
`define LCU_ADDR_TXSTAT 4'h3
`define LCU_ADDR_CTRL 4'h4
`define LCU_ADDR_ROUTE 4'h5
`define LCU_ADDR_BAUD 4'h6
`define LCU_ADDR_RXSTAT 4'h7
// mode register fields
`define LCU_MODE_POWER 7
`define LCU_MODE_TXE 6
`define LCU_MODE_RXE 5
`define LCU_MODE_CL 2
`define LCU_MODE_RST 8'h01
// control register fields
`define LCU_CTRL_BRK_GO 7
`define LCU_CTRL_BRK_RX 6
`define LCU_CTRL_BLEN_HI 4
`define LCU_CTRL_BLEN_LO 2
`define LCU_CTRL_MSB 1
`define LCU_CTRL_RST 8'h00
// status fields
`define LCU_TXS_FULL 1
`define LCU_TXS_BUSY 0
`define LCU_RXS_OVR 0
`define LCU_RXS_FRM 1
`define LCU_RXS_BRKERR 2
// break length base: field value 0 means 13 bits
`define LCU_BRK_BASE 5'h0d
`define LCU_BRK_MIN 5'h0b
`define LCU_BUF_RST 8'hff
`define LCU_BAUD_RST 8'h10
`endif

/* File: src/lcu_div.v */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// base clock divider: one-cycle enable pulses
// ----------------------------------------
module lcu_div #(
   parameter W = 8
) (
   input wire core_clk_i,
   input wire arst_n_i,
   input wire run_i,
   input wire [W-1:0] div_i,
   output reg tick_o
);
   reg [W-1:0] cnt_reg;
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= {W{1'b0}};
         tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_reg <= {W{1'b0}};
         tick_o <= 1'b0;
      end else if (cnt_reg >= div_i) begin
         cnt_reg <= {W{1'b0}};
         tick_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: src/lcu_top.v */
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcu_defines.vh"
module lcu_top #(
   parameter DIVW = 8
) (
   input wire core_clk_i,
   input wire arst_n_i,
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   input wire serial_rx_pin_i,
   output reg serial_tx_pin_o,
   output wire external_irq_zero_o,
   output wire capture_timer_input_o,
   output reg transmit_done_irq_o,
   output reg break_rx_irq_o,
   output reg receive_done_o
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] mode_reg;
   reg [7:0] ctrl_reg;
   reg [1:0] route_reg;
   reg [7:0] baud_reg;
   reg [7:0] receive_data_buffer_reg;
   reg [7:0] transmit_data_buffer_reg;
   reg tx_full_reg;
   reg ovr_reg;
   reg frm_reg;
   reg brkerr_reg;
   reg ack_reg;
   wire power = mode_reg[`LCU_MODE_POWER];
   wire char8 = mode_reg[`LCU_MODE_CL];
   wire msb_first = ctrl_reg[`LCU_CTRL_MSB];
   wire wr_ok = avs_write_i & ~ack_reg & avs_byteenable_i[0];
   wire rd_ok = avs_read_i & ~ack_reg;
   wire wr_tx = wr_ok & (avs_address_i == `LCU_ADDR_TXBUF);
   wire rd_rx = rd_ok & (avs_address_i == `LCU_ADDR_RXBUF);
   wire rd_rxs = rd_ok & (avs_address_i == `LCU_ADDR_RXSTAT);
   // one wait state: request taken on first edge, answered on the second
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
   wire tick;
   lcu_div #(.W(DIVW)) u_div (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .run_i(power),
      .div_i(baud_reg),
      .tick_o(tick)
   );
   // ----------------------------------------
   // enables delayed by one base tick
   // ----------------------------------------
   reg tx_en_reg;
   reg rx_en_reg;
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_en_reg <= 1'b0;
         rx_en_reg <= 1'b0;
      end else begin
         if (!(power & mode_reg[`LCU_MODE_TXE]))
            tx_en_reg <= 1'b0;
         else if (tick)
            tx_en_reg <= 1'b1;
         if (!(power & mode_reg[`LCU_MODE_RXE]))
            rx_en_reg <= 1'b0;
         else if (tick)
            rx_en_reg <= 1'b1;
      end
   end
   assign external_irq_zero_o = route_reg[0] & serial_rx_pin_i;
   assign capture_timer_input_o = route_reg[1] & serial_rx_pin_i;
   // ----------------------------------------
   // transmitter: one bit per 16 ticks
   // ----------------------------------------
   localparam TX_IDLE = 2'd0;
   localparam TX_DATA = 2'd1;
   localparam TX_BRK = 2'd2;
   reg [1:0] tx_st_reg;
   reg [9:0] tx_sh_reg;
   reg [3:0] tx_bits_reg;
   reg [3:0] tx_os_reg;
   reg [4:0] tx_brk_reg;
   // length taken from the same write that starts the break, not the stale field
   wire [4:0] brk_len = `LCU_BRK_BASE + {2'b00, avs_writedata_i[`LCU_CTRL_BLEN_HI:`LCU_CTRL_BLEN_LO]};
   wire brk_go = wr_ok & (avs_address_i == `LCU_ADDR_CTRL) & avs_writedata_i[`LCU_CTRL_BRK_GO];
   wire [6:0] tx7 = msb_first ? transmit_data_buffer_reg[7:1] : transmit_data_buffer_reg[6:0];
   wire [7:0] tx8 = char8 ? transmit_data_buffer_reg : {1'b1, tx7};
   reg [7:0] tx_ord;
   integer i;
   always @* begin
      tx_ord = tx8;
      if (msb_first) begin
         for (i = 0; i < 8; i = i + 1)
            tx_ord[i] = char8 ? tx8[7-i] : (i < 7 ? tx7[6-i] : 1'b1);
      end
   end
   wire tx_bit_end = tick & (tx_os_reg == 4'hf);
   wire tx_last = (tx_st_reg == TX_DATA) & tx_bit_end & (tx_bits_reg == 4'h1);
   wire tx_load = tx_en_reg & tx_full_reg & ((tx_st_reg == TX_IDLE) | tx_last);
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_st_reg <= TX_IDLE;
         tx_sh_reg <= 10'h3ff;
         tx_bits_reg <= 4'h0;
         tx_os_reg <= 4'h0;
         tx_brk_reg <= 5'h00;
         serial_tx_pin_o <= 1'b1;
         transmit_done_irq_o <= 1'b0;
      end else if (!tx_en_reg) begin
         tx_st_reg <= TX_IDLE;
         tx_os_reg <= 4'h0;
         serial_tx_pin_o <= 1'b1;
         transmit_done_irq_o <= 1'b0;
      end else begin
         transmit_done_irq_o <= 1'b0;
         if (tick)
            tx_os_reg <= tx_os_reg + 4'h1;
         case (tx_st_reg)
            TX_IDLE: begin
               tx_os_reg <= 4'h0;
               if (tx_load) begin
                  // start, data, stop; 80h in 8-bit mode is the wakeup frame
                  tx_sh_reg <= {1'b1, tx_ord, 1'b0};
                  tx_bits_reg <= char8 ? 4'd10 : 4'd9;
                  tx_st_reg <= TX_DATA;
               end else if (brk_go) begin
                  tx_brk_reg <= brk_len;
                  tx_st_reg <= TX_BRK;
               end
            end
            TX_DATA: begin
               serial_tx_pin_o <= tx_sh_reg[0];
               if (tx_bit_end) begin
                  tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                  tx_bits_reg <= tx_bits_reg - 4'h1;
                  if (tx_bits_reg == 4'h1) begin
                     transmit_done_irq_o <= 1'b1;
                     if (tx_load) begin
                        tx_sh_reg <= {1'b1, tx_ord, 1'b0};
                        tx_bits_reg <= char8 ? 4'd10 : 4'd9;
                     end else begin
                        tx_st_reg <= TX_IDLE;
                     end
                  end
               end
            end
            TX_BRK: begin
               serial_tx_pin_o <= 1'b0;
               if (tx_bit_end) begin
                  tx_brk_reg <= tx_brk_reg - 5'h01;
                  if (tx_brk_reg == 5'h01) begin
                     tx_st_reg <= TX_IDLE;
                     serial_tx_pin_o <= 1'b1;
                     transmit_done_irq_o <= 1'b1;
                  end
               end
            end
            default: tx_st_reg <= TX_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // receiver: sample mid-bit, 16 ticks a bit
   // ----------------------------------------
   localparam RX_IDLE = 2'd0;
   localparam RX_DATA = 2'd1;
   localparam RX_BRK = 2'd2;
   reg [1:0] rx_st_reg;
   reg [7:0] receive_shifter_reg;
   reg [3:0] rx_os_reg;
   reg [3:0] rx_cnt_reg;
   reg [4:0] rx_low_reg;
   reg rx_unread_reg;
   wire brk_mode = ctrl_reg[`LCU_CTRL_BRK_RX];
   wire rx_mid = tick & (rx_os_reg == 4'h7);
   wire [3:0] rx_nbits = char8 ? 4'd8 : 4'd7;
   reg [7:0] rx_word;
   always @* begin
      rx_word = receive_shifter_reg;
      if (!char8)
         rx_word = msb_first ? {receive_shifter_reg[6:0], 1'b0}
                             : {1'b0, receive_shifter_reg[7:1]};
   end
   reg rx_done;
   reg rx_ovr_ev;
   reg rx_frm_ev;
   reg rx_brkerr_ev;
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_st_reg <= RX_IDLE;
         receive_shifter_reg <= `LCU_BUF_RST;
         rx_os_reg <= 4'h0;
         rx_cnt_reg <= 4'h0;
         rx_low_reg <= 5'h00;
         rx_done <= 1'b0;
         rx_ovr_ev <= 1'b0;
         rx_frm_ev <= 1'b0;
         rx_brkerr_ev <= 1'b0;
         break_rx_irq_o <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         rx_ovr_ev <= 1'b0;
         rx_frm_ev <= 1'b0;
         rx_brkerr_ev <= 1'b0;
         break_rx_irq_o <= 1'b0;
         if (tick)
            rx_os_reg <= rx_os_reg + 4'h1;
         if (!rx_en_reg) begin
            rx_st_reg <= RX_IDLE;
            receive_shifter_reg <= `LCU_BUF_RST;
         end else begin
            case (rx_st_reg)
               RX_IDLE: begin
                  rx_os_reg <= 4'h0;
                  rx_cnt_reg <= 4'h0;
                  rx_low_reg <= 5'h00;
                  if (!serial_rx_pin_i)
                     rx_st_reg <= brk_mode ? RX_BRK : RX_DATA;
               end
               RX_BRK: begin
                  receive_shifter_reg <= `LCU_BUF_RST;
                  if (rx_mid) begin
                     if (!serial_rx_pin_i) begin
                        if (rx_low_reg != 5'h1f)
                           rx_low_reg <= rx_low_reg + 5'h01;
                     end else begin
                        // stop bit ends the break
                        rx_st_reg <= RX_IDLE;
                        if (rx_low_reg >= `LCU_BRK_MIN)
                           break_rx_irq_o <= 1'b1;
                        else
                           rx_brkerr_ev <= 1'b1;
                     end
                  end
               end
               RX_DATA: begin
                  if (rx_mid) begin
                     rx_cnt_reg <= rx_cnt_reg + 4'h1;
                     if (rx_cnt_reg == 4'h0) begin
                        if (serial_rx_pin_i)
                           rx_st_reg <= RX_IDLE;
                     end else if (rx_cnt_reg <= rx_nbits) begin
                        if (msb_first)
                           receive_shifter_reg <= {receive_shifter_reg[6:0], serial_rx_pin_i};
                        else
                           receive_shifter_reg <= {serial_rx_pin_i, receive_shifter_reg[7:1]};
                     end else begin
                        rx_st_reg <= RX_IDLE;
                        rx_frm_ev <= ~serial_rx_pin_i;
                        if (rx_unread_reg)
                           rx_ovr_ev <= 1'b1;
                        else
                           rx_done <= 1'b1;
                     end
                  end
               end
               default: rx_st_reg <= RX_IDLE;
            endcase
         end
      end
   end
   // ----------------------------------------
   // buffers and status
   // ----------------------------------------
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         receive_data_buffer_reg <= `LCU_BUF_RST;
         transmit_data_buffer_reg <= `LCU_BUF_RST;
         tx_full_reg <= 1'b0;
         rx_unread_reg <= 1'b0;
         receive_done_o <= 1'b0;
         ovr_reg <= 1'b0;
         frm_reg <= 1'b0;
         brkerr_reg <= 1'b0;
      end else begin
         receive_done_o <= rx_done;
         if (!power)
            receive_data_buffer_reg <= `LCU_BUF_RST;
         else if (rx_done)
            receive_data_buffer_reg <= rx_word;
         if (wr_tx)
            transmit_data_buffer_reg <= avs_writedata_i[7:0];
         // set wins over clear
         if (wr_tx)
            tx_full_reg <= 1'b1;
         else if (tx_load | ~tx_en_reg)
            tx_full_reg <= 1'b0;
         if (rx_done)
            rx_unread_reg <= 1'b1;
         else if (rd_rx | ~rx_en_reg)
            rx_unread_reg <= 1'b0;
         ovr_reg <= rx_ovr_ev | (ovr_reg & ~rd_rxs & rx_en_reg);
         frm_reg <= rx_frm_ev | (frm_reg & ~rd_rxs & rx_en_reg);
         brkerr_reg <= rx_brkerr_ev | (brkerr_reg & ~rd_rxs & rx_en_reg);
      end
   end
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_reg <= `LCU_MODE_RST;
         ctrl_reg <= `LCU_CTRL_RST;
         route_reg <= 2'b00;
         baud_reg <= `LCU_BAUD_RST;
         ack_reg <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
         if (wr_ok) begin
            case (avs_address_i)
               `LCU_ADDR_MODE: mode_reg <= avs_writedata_i[7:0];
               `LCU_ADDR_CTRL: ctrl_reg <= {1'b0, avs_writedata_i[6:0]};
               `LCU_ADDR_ROUTE: route_reg <= avs_writedata_i[1:0];
               `LCU_ADDR_BAUD: baud_reg <= avs_writedata_i[7:0];
               default: ;
            endcase
         end
         if (rd_ok) begin
            case (avs_address_i)
               `LCU_ADDR_RXBUF: avs_readdata_o <= {24'h000000, receive_data_buffer_reg};
               `LCU_ADDR_TXBUF: avs_readdata_o <= {24'h000000, transmit_data_buffer_reg};
               `LCU_ADDR_MODE: avs_readdata_o <= {24'h000000, mode_reg};
               `LCU_ADDR_TXSTAT: avs_readdata_o <= {30'h0, tx_full_reg, tx_st_reg != TX_IDLE};
               `LCU_ADDR_CTRL: avs_readdata_o <= {24'h000000, tx_st_reg == TX_BRK, ctrl_reg[6:0]};
               `LCU_ADDR_ROUTE: avs_readdata_o <= {30'h0, route_reg};
               `LCU_ADDR_BAUD: avs_readdata_o <= {24'h000000, baud_reg};
               `LCU_ADDR_RXSTAT: avs_readdata_o <= {29'h0, brkerr_reg, frm_reg, ovr_reg};
               default: avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/lcu_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module lcu_top_props #(
   parameter int BIT_CYC = 32
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic serial_rx_pin_i,
   input wire logic serial_tx_pin_o,
   input wire logic external_irq_zero_o,
   input wire logic capture_timer_input_o,
   input wire logic transmit_done_irq_o,
   input wire logic break_rx_irq_o,
   input wire logic receive_done_o
);
   // mid-bit sampling can see 11 bits in a little over 10 bit times
   localparam int LO_MIN = 10 * BIT_CYC;
   logic [15:0] lo_run_reg;
   logic [15:0] lo_last_reg;
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lo_run_reg <= 16'h0000;
         lo_last_reg <= 16'h0000;
      end else if (!serial_rx_pin_i) begin
         lo_run_reg <= lo_run_reg + 16'h0001;
      end else begin
         lo_run_reg <= 16'h0000;
         if (lo_run_reg != 16'h0000) begin
            lo_last_reg <= lo_run_reg;
         end
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   AST_IDLE_NO_WAIT: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest high without a request");
   AST_REQ_WAITS: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("request not answered after one wait state");
   AST_RDATA_HOLD: assert property (!avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   AST_ROUTE_IRQ: assert property (!serial_rx_pin_i |-> !external_irq_zero_o)
      else $error("irq route not following rx pin");
   AST_ROUTE_TMR: assert property (!serial_rx_pin_i |-> !capture_timer_input_o)
      else $error("timer route not following rx pin");
   AST_TXDONE_PULSE: assert property (transmit_done_irq_o |=> !transmit_done_irq_o)
      else $error("transmit done longer than one cycle");
   AST_TXDONE_STOP: assert property (transmit_done_irq_o |-> serial_tx_pin_o || $past(serial_tx_pin_o))
      else $error("transmit done without stop level");
   AST_BRK_PULSE: assert property (break_rx_irq_o |=> !break_rx_irq_o)
      else $error("break irq longer than one cycle");
   AST_BRK_LEN: assert property (break_rx_irq_o |-> serial_rx_pin_i && lo_last_reg >= LO_MIN)
      else $error("break irq after short low period");
   AST_RXDONE_PULSE: assert property (receive_done_o |=> !receive_done_o [*8])
      else $error("receive done repeated too soon");
   AST_TX_BIT_HOLD: assert property ($changed(serial_tx_pin_o) |=> $stable(serial_tx_pin_o) [*8])
      else $error("tx pin changed faster than a bit");
   COV_BRK: cover property (break_rx_irq_o);
   COV_TXD: cover property (transmit_done_irq_o);
   COV_RXD: cover property (receive_done_o);
endmodule
`default_nettype wire

/* File: verification/lcu_lin_node.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side node: drives rx line, decodes tx line
// ----------------------------------------
module lcu_lin_node #(
   parameter int BIT = 32
) (
   input wire logic clk_i,
   input wire logic line_i,
   output logic line_o
);
   logic [8:0] word = 9'h000;
   int rx_count = 0;
   int low_run = 0;
   int last_low = 0;
   initial line_o = 1'b1;
   task automatic send_bits(input logic [31:0] pat, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         line_o <= pat[i];
         repeat (BIT - 1) @(posedge clk_i);
      end
   endtask
   // start, nb data bits first-out first, then stop and one idle bit
   task automatic send_char(input logic [7:0] d, input int nb);
      send_bits((32'h3 << (nb + 1)) | ({24'h0, d & 8'((1 << nb) - 1)} << 1), nb + 3);
   endtask
   task automatic send_break(input int n);
      send_bits(32'h3 << n, n + 2);
   endtask
   always @(negedge clk_i) begin
      if (line_i === 1'b0) begin
         low_run <= low_run + 1;
      end else begin
         if (low_run != 0) begin
            last_low <= low_run;
         end
         low_run <= 0;
      end
   end
   // a break reads as all zeros and is waited out before counting
   initial forever begin
      @(negedge line_i);
      repeat (BIT / 2) @(negedge clk_i);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(negedge clk_i);
         word[i] = line_i;
      end
      wait (line_i === 1'b1);
      rx_count++;
   end
endmodule
`default_nettype wire

/* File: verification/tb_lin_capable_uart_datapath.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcu_defines.vh"
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         bad_count++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module tb_lin_capable_uart_datapath;
   localparam int BIT = 32;
   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hf;
   wire [31:0] rdat;
   wire wreq, rx, tx, ext, cap, txd, brk, rxd;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int txd_n = 0;
   int brk_n = 0;
   int rxd_n = 0;
   int m;
   int n;
   logic [7:0] q, v, r;
   initial forever #4 core_clk_i = ~core_clk_i;
   lcu_top uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .serial_rx_pin_i(rx), .serial_tx_pin_o(tx), .external_irq_zero_o(ext),
      .capture_timer_input_o(cap), .transmit_done_irq_o(txd), .break_rx_irq_o(brk), .receive_done_o(rxd));
   lcu_lin_node #(.BIT(BIT)) node (.clk_i(core_clk_i), .line_i(tx), .line_o(rx));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (txd === 1'b1) txd_n <= txd_n + 1;
      if (brk === 1'b1) brk_n <= brk_n + 1;
      if (rxd === 1'b1) rxd_n <= rxd_n + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         stop_test();
      end
   end
   function automatic logic [7:0] rev8(input logic [7:0] x);
      for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
   endfunction
   // ----------------------------------------
   // avalon master: hold until waitrequest seen low at an edge
   // ----------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] o);
      @(posedge core_clk_i);
      adr <= a;
      wdat <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      do @(posedge core_clk_i); while (wreq !== 1'b0);
      o = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic bw(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask
   task automatic wait_bits(input int k);
      repeat (k * BIT) @(posedge core_clk_i);
   endtask
   task automatic wait_node(input int k);
      while (node.rx_count < k) @(posedge core_clk_i);
   endtask
   initial begin
      repeat (8) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      chk_rd(`LCU_ADDR_RXBUF, 8'hff);
      chk_rd(`LCU_ADDR_TXBUF, 8'hff);
      chk_rd(`LCU_ADDR_MODE, `LCU_MODE_RST);
      bw(`LCU_ADDR_RXBUF, 8'h00);
      chk_rd(`LCU_ADDR_RXBUF, 8'hff);
      chk_rd(4'hf, 8'h00);
      bw(`LCU_ADDR_ROUTE, 8'h01);
      @(negedge core_clk_i);
      `CHK({ext, cap}, 2'b10)
      bw(`LCU_ADDR_ROUTE, 8'h02);
      @(negedge core_clk_i);
      `CHK({ext, cap}, 2'b01)
      bw(`LCU_ADDR_ROUTE, 8'h03);
      bw(`LCU_ADDR_BAUD, 8'h01);
      // low byte lane disabled: write is acked but ignored
      be <= 4'he;
      bw(`LCU_ADDR_BAUD, 8'h55);
      be <= 4'hf;
      chk_rd(`LCU_ADDR_BAUD, 8'h01);
      // each length and order: one character out, one in
      for (m = 0; m < 4; m++) begin
         bw(`LCU_ADDR_MODE, 8'h80);
         bw(`LCU_ADDR_CTRL, {6'h00, m[0], 1'b0});
         bw(`LCU_ADDR_MODE, {5'h1c, ~m[1], 2'b00});
         wait_bits(1);
         v = 8'hc1 ^ 8'(m);
         n = node.rx_count + 1;
         bw(`LCU_ADDR_TXBUF, v);
         chk_rd(`LCU_ADDR_TXBUF, v);
         wait_node(n);
         r = rev8(v);
         `CHK(node.word[7:0], m[1] ? {1'b1, m[0] ? r[6:0] : v[6:0]} : (m[0] ? r : v))
         v = 8'h35 ^ 8'(m << 4);
         n = rxd_n + 1;
         node.send_char(v, m[1] ? 7 : 8);
         while (rxd_n < n) @(posedge core_clk_i);
         r = m[1] ? {1'b0, v[6:0]} : v;
         chk_rd(`LCU_ADDR_RXBUF, m[0] ? rev8(r) : r);
      end
      bw(`LCU_ADDR_MODE, 8'h80);
      bw(`LCU_ADDR_CTRL, 8'h00);
      bw(`LCU_ADDR_MODE, 8'he4);
      wait_bits(1);
      n = node.rx_count;
      bw(`LCU_ADDR_TXBUF, 8'h80);
      do bus(1'b0, `LCU_ADDR_TXSTAT, 8'h00, q); while (q[`LCU_TXS_FULL] !== 1'b0);
      bw(`LCU_ADDR_TXBUF, 8'h3c);
      chk_rd(`LCU_ADDR_TXSTAT, 8'h03);
      wait_node(n + 1);
      `CHK(node.word[7:0], 8'h80)
      wait_node(n + 2);
      `CHK(node.word[7:0], 8'h3c)
      wait_bits(2);
      `CHK(txd_n, 6)
      // unread character overrun by a second one
      node.send_char(8'h11, 8);
      node.send_char(8'h22, 8);
      wait_bits(2);
      chk_rd(`LCU_ADDR_RXSTAT, 8'h01);
      chk_rd(`LCU_ADDR_RXBUF, 8'h11);
      for (m = 0; m < 8; m += 7) begin
         n = node.rx_count + 1;
         bw(`LCU_ADDR_CTRL, 8'h80 | 8'(m << 2));
         wait_node(n);
         wait_bits(1);
         `CHK((node.last_low + BIT / 2) / BIT, 13 + m)
      end
      `CHK(txd_n, 8)
      bw(`LCU_ADDR_CTRL, 8'h40);
      n = rxd_n;
      node.send_break(8);
      wait_bits(2);
      `CHK(brk_n, 0)
      chk_rd(`LCU_ADDR_RXSTAT, 8'h04);
      node.send_break(12);
      wait_bits(2);
      `CHK(brk_n, 1)
      chk_rd(`LCU_ADDR_RXSTAT, 8'h00);
      chk_rd(`LCU_ADDR_RXBUF, 8'h11);
      `CHK(rxd_n, n)
      stop_test();
   end
endmodule
bind lcu_top lcu_top_props #(.BIT_CYC(32)) u_props (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .serial_rx_pin_i(serial_rx_pin_i), .serial_tx_pin_o(serial_tx_pin_o),
   .external_irq_zero_o(external_irq_zero_o), .capture_timer_input_o(capture_timer_input_o),
   .transmit_done_irq_o(transmit_done_irq_o), .break_rx_irq_o(break_rx_irq_o), .receive_done_o(receive_done_o));
`default_nettype wire
